// >>> hw/cspm_defs.vh
// Purpose: Shared constants for the clock source and power mode control block
// Assumes: 40 MHz pclk, 32-bit APB register words
// Notes:   Definitions only
`ifndef CSPM_DEFS_VH
`define CSPM_DEFS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CSPM_OFF_OSC_CTRL      12'h000
`define CSPM_OFF_OSC_SECOND    12'h004
`define CSPM_OFF_STATUS        12'h008

// ----------------------------------------
// Oscillator control fields and reset
// ----------------------------------------
`define CSPM_BIT_IDLE          7
`define CSPM_FREQ_HI           6
`define CSPM_FREQ_LO           4
`define CSPM_BIT_START_STAT    3
`define CSPM_BIT_HF_STABLE     2
`define CSPM_SRC_HI            1
`define CSPM_SRC_LO            0
`define CSPM_RST_IDLE          1'h0
`define CSPM_RST_FREQ          3'h3
`define CSPM_RST_SRC           2'h0
`define CSPM_RST_SECOND        5'h00

// ----------------------------------------
// Second control fields
// ----------------------------------------
`define CSPM_BIT_LOW_SRC       0
`define CSPM_BIT_MID_PATH      1
`define CSPM_BIT_WDT_EN        2
`define CSPM_BIT_TMR_SEC       3
`define CSPM_BIT_LF_KEEP       4
`define CSPM_SECOND_W          5

// ----------------------------------------
// Frequency codes and divider exponents
// ----------------------------------------
`define CSPM_FREQ_DIV16        3'h3
`define CSPM_FREQ_500K         3'h2
`define CSPM_FREQ_250K         3'h1
`define CSPM_FREQ_LOW          3'h0
`define CSPM_DIV_MAX           4'h7
`define CSPM_DIV_HF32          4'h5
`define CSPM_DIV_HF64          4'h6
`define CSPM_DIV_HF512         4'h9
`define CSPM_DIV_MF1           4'h0
`define CSPM_DIV_MF2           4'h1
`define CSPM_DIV_MF16          4'h4

// ----------------------------------------
// Clock sources and internal paths
// ----------------------------------------
`define CSPM_SRC_PRIMARY       2'h0
`define CSPM_SRC_SECONDARY     2'h1
`define CSPM_SRC_INTERNAL      2'h2
`define CSPM_PATH_HF           2'h0
`define CSPM_PATH_MF           2'h1
`define CSPM_PATH_LF           2'h2

// ----------------------------------------
// Primary oscillator configuration codes
// ----------------------------------------
`define CSPM_CFG_XTAL_MAX      4'h3
`define CSPM_CFG_INT_A         4'h8
`define CSPM_CFG_INT_B         4'h9

// ----------------------------------------
// Operating modes
// ----------------------------------------
`define CSPM_MODE_PRI_RUN      3'h0
`define CSPM_MODE_SECONDARY_RUN_MODE      3'h1
`define CSPM_MODE_INT_RUN      3'h2
`define CSPM_MODE_PRIMARY_IDLE_MODE     3'h3
`define CSPM_MODE_SECONDARY_IDLE_MODE     3'h4
`define CSPM_MODE_INT_IDLE     3'h5
`define CSPM_MODE_SLEEP        3'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSPM_CLK_KHZ           40000
`define CSPM_POWER_UP_TIMER_TICKS        2048
`define CSPM_OST_TICKS         1024
`define CSPM_PLL_LOCK_US       2000
`define CSPM_CORE_READY_US     10
`define CSPM_CNT_W             17

`endif

// >>> hw/cspm_counter.v
// Purpose: Loadable down counter used for the power-up delays
// Assumes: Count advances only on tick
// Notes:   Done is registered and holds until the next load
`timescale 1ns/100ps
`default_nettype none

module cspm_counter #(
	parameter W = 17
) (
	// Clock and reset
	input  wire         pclk,
	input  wire         presetn,
	// Control
	input  wire         load,
	input  wire [W-1:0] load_val,
	input  wire         tick,
	// Status
	output reg          done_q
);

	reg [W-1:0] cnt_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q  <= {W{1'b0}};
			done_q <= 1'b0;
		end
		else if (load)
		begin
			cnt_q  <= load_val;
			done_q <= (load_val == {W{1'b0}});
		end
		else if (tick && !done_q)
		begin
			cnt_q  <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			done_q <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
		end
	end

endmodule

`default_nettype wire

// >>> hw/cspm_top.v
// Purpose: Clock source selection, oscillator enables and power-up delay control
// Assumes: Oscillator ticks and ready levels are synchronous to pclk
// Notes:   APB slave, zero wait states
`timescale 1ns/100ps
`default_nettype none
`include "cspm_defs.vh"

module cspm_top #(
	parameter PLL_LOCK_CYC   = (`CSPM_PLL_LOCK_US * `CSPM_CLK_KHZ) / 1000,
	parameter CORE_READY_CYC = (`CSPM_CORE_READY_US * `CSPM_CLK_KHZ) / 1000
) (
	// APB
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Configuration bits
	input  wire        power_up_timer_config,
	input  wire [3:0]  primary_osc_config,
	input  wire        hf_start_wait_config,
	input  wire        pll_enable,
	// Oscillator status
	input  wire        primary_osc_tick,
	input  wire        low_freq_tick,
	input  wire        hf_osc_ready,
	input  wire        secondary_osc_running,
	// Core events
	input  wire        sleep_instr,
	input  wire        wake_event,
	// Oscillator enables
	output reg         primary_osc_en_q,
	output reg         secondary_osc_en_q,
	output reg         high_freq_internal_osc_en_q,
	output reg         mid_freq_internal_osc_en_q,
	output reg         low_freq_internal_osc_en_q,
	// Clock routing
	output reg  [1:0]  clk_source_q,
	output reg  [1:0]  internal_path_q,
	output reg  [3:0]  postscale_log2_q,
	output reg         cpu_clk_en_q,
	output reg         periph_clk_en_q,
	output reg         async_wake_en_q,
	output reg         device_reset_hold_q,
	output reg  [2:0]  mode_q
);

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	localparam [2:0] S_POWER_UP_TIMER = 3'h0;
	localparam [2:0] S_OST  = 3'h1;
	localparam [2:0] S_PLL  = 3'h2;
	localparam [2:0] S_HFW  = 3'h3;
	localparam [2:0] S_RUN  = 3'h4;
	localparam [2:0] S_INIT = 3'h5;

	localparam [`CSPM_CNT_W-1:0] POWER_UP_TIMER_LOAD = `CSPM_POWER_UP_TIMER_TICKS;
	localparam [`CSPM_CNT_W-1:0] OST_LOAD  = `CSPM_OST_TICKS;
	localparam [`CSPM_CNT_W-1:0] PLL_LOAD  = PLL_LOCK_CYC;
	localparam [`CSPM_CNT_W-1:0] CORE_LOAD = CORE_READY_CYC;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg                    idle_on_sleep_select_q;
	reg [2:0]              internal_freq_select_q;
	reg [1:0]              system_clock_source_select_q;
	reg [`CSPM_SECOND_W-1:0] second_q;
	reg                    sleep_q;
	reg                    idle_q;
	reg [2:0]              state_q;
	reg [2:0]              state_d;
	reg                    seq_load;
	reg [`CSPM_CNT_W-1:0]  seq_val;
	reg                    seq_tick;
	reg                    core_start_q;
	reg [3:0]              div_d;
	reg [1:0]              path_d;
	reg [31:0]             rdata_d;
	reg                    err_d;
	wire                   seq_done;
	wire                   core_done;

	wire low_source_select = second_q[`CSPM_BIT_LOW_SRC];
	wire mid_path_select   = second_q[`CSPM_BIT_MID_PATH];
	wire watchdog_en       = second_q[`CSPM_BIT_WDT_EN];
	wire timer_needs_sec   = second_q[`CSPM_BIT_TMR_SEC];
	wire lf_keep           = second_q[`CSPM_BIT_LF_KEEP];

	wire prim_xtal = (primary_osc_config <= `CSPM_CFG_XTAL_MAX);
	wire prim_int  = (primary_osc_config == `CSPM_CFG_INT_A) ||
		(primary_osc_config == `CSPM_CFG_INT_B);

	wire wr_en = psel && penable && pready && pwrite;
	wire booted = (state_q == S_RUN) && core_done;

	// ----------------------------------------
	// Power-up delays
	// ----------------------------------------
	cspm_counter #(
		.W (`CSPM_CNT_W)
	) u_seq_cnt (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (seq_load),
		.load_val (seq_val),
		.tick     (seq_tick),
		.done_q   (seq_done)
	);

	cspm_counter #(
		.W (`CSPM_CNT_W)
	) u_core_cnt (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (core_start_q),
		.load_val (CORE_LOAD),
		.tick     (1'b1),
		.done_q   (core_done)
	);

	always @*
	begin
		state_d  = state_q;
		seq_load = 1'b0;
		seq_val  = {`CSPM_CNT_W{1'b0}};
		seq_tick = 1'b0;
		case (state_q)
			S_INIT:
			begin
				state_d  = S_POWER_UP_TIMER;
				seq_load = 1'b1;
				seq_val  = power_up_timer_config ? {`CSPM_CNT_W{1'b0}} : POWER_UP_TIMER_LOAD;
			end
			S_POWER_UP_TIMER:
			begin
				seq_tick = low_freq_tick;
				if (seq_done)
				begin
					state_d  = S_OST;
					seq_load = 1'b1;
					seq_val  = prim_xtal ? OST_LOAD : {`CSPM_CNT_W{1'b0}};
				end
			end
			S_OST:
			begin
				seq_tick = primary_osc_tick;
				if (seq_done)
				begin
					state_d  = S_PLL;
					seq_load = 1'b1;
					seq_val  = (pll_enable && !prim_int) ? PLL_LOAD : {`CSPM_CNT_W{1'b0}};
				end
			end
			S_PLL:
			begin
				seq_tick = 1'b1;
				if (seq_done)
					state_d = S_HFW;
			end
			S_HFW:
			begin
				if (!prim_int || hf_start_wait_config || hf_osc_ready)
					state_d = S_RUN;
			end
			S_RUN:
			begin
				if (wake_event && sleep_q && prim_xtal &&
					system_clock_source_select_q == `CSPM_SRC_PRIMARY)
				begin
					state_d  = S_OST;
					seq_load = 1'b1;
					seq_val  = OST_LOAD;
				end
			end
			default:
				state_d = S_INIT;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q      <= S_INIT;
			core_start_q <= 1'b0;
		end
		else
		begin
			state_q      <= state_d;
			core_start_q <= (state_q == S_INIT);
		end
	end

	// ----------------------------------------
	// Register file and power-managed mode
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_on_sleep_select_q       <= `CSPM_RST_IDLE;
			internal_freq_select_q       <= `CSPM_RST_FREQ;
			system_clock_source_select_q <= `CSPM_RST_SRC;
			second_q                     <= `CSPM_RST_SECOND;
			sleep_q                      <= 1'b0;
			idle_q                       <= 1'b0;
		end
		else
		begin
			if (wr_en && paddr == `CSPM_OFF_OSC_CTRL)
			begin
				idle_on_sleep_select_q       <= pwdata[`CSPM_BIT_IDLE];
				internal_freq_select_q       <= pwdata[`CSPM_FREQ_HI:`CSPM_FREQ_LO];
				system_clock_source_select_q <= pwdata[`CSPM_SRC_HI:`CSPM_SRC_LO];
			end
			if (wr_en && paddr == `CSPM_OFF_OSC_SECOND)
				second_q <= pwdata[`CSPM_SECOND_W-1:0];
			// Wake wins over a sleep in the same cycle so an event is never lost
			if (wake_event)
			begin
				sleep_q <= 1'b0;
				idle_q  <= 1'b0;
			end
			else if (sleep_instr && booted)
			begin
				sleep_q <= !idle_on_sleep_select_q;
				idle_q  <= idle_on_sleep_select_q;
			end
		end
	end

	// ----------------------------------------
	// Internal path and postscaler
	// ----------------------------------------
	always @*
	begin
		path_d = `CSPM_PATH_HF;
		div_d  = `CSPM_DIV_MAX - {1'b0, internal_freq_select_q};
		if (internal_freq_select_q < `CSPM_FREQ_DIV16)
		begin
			if (mid_path_select)
			begin
				path_d = `CSPM_PATH_MF;
				if (internal_freq_select_q == `CSPM_FREQ_500K)
					div_d = `CSPM_DIV_MF1;
				else if (internal_freq_select_q == `CSPM_FREQ_250K)
					div_d = `CSPM_DIV_MF2;
				else if (low_source_select)
					div_d = `CSPM_DIV_MF16;
				else
				begin
					path_d = `CSPM_PATH_LF;
					div_d  = `CSPM_DIV_MF1;
				end
			end
			else if (internal_freq_select_q == `CSPM_FREQ_500K)
				div_d = `CSPM_DIV_HF32;
			else if (internal_freq_select_q == `CSPM_FREQ_250K)
				div_d = `CSPM_DIV_HF64;
			else if (low_source_select)
				div_d = `CSPM_DIV_HF512;
			else
			begin
				path_d = `CSPM_PATH_LF;
				div_d  = `CSPM_DIV_MF1;
			end
		end
	end

	// ----------------------------------------
	// Oscillator enables and clock routing
	// ----------------------------------------
	wire       pri_sel    = (system_clock_source_select_q == `CSPM_SRC_PRIMARY);
	wire       sec_sel    = (system_clock_source_select_q == `CSPM_SRC_SECONDARY);
	wire       int_sel    = system_clock_source_select_q[`CSPM_SRC_HI];
	wire [1:0] req_src    = int_sel ? `CSPM_SRC_INTERNAL : system_clock_source_select_q;
	wire       int_block  = !sleep_q && (int_sel || (pri_sel && prim_int));
	wire       lf_direct  = int_block && (path_d == `CSPM_PATH_LF);
	wire       hold_reset = !booted;
	// Primary counts as running once the sequencer reaches S_RUN, or at once for an internal config
	wire       pri_ready  = prim_int ? 1'b1 : (state_q == S_RUN);
	wire       src_ready  = (req_src == `CSPM_SRC_PRIMARY)   ? pri_ready :
		(req_src == `CSPM_SRC_SECONDARY) ? secondary_osc_running : 1'b1;
	// Mode and enables move on the same edge; enables follow the requested source, while mode and clk_source_q wait until it runs
	wire [1:0] src_d      = src_ready ? req_src : clk_source_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			primary_osc_en_q            <= 1'b0;
			secondary_osc_en_q          <= 1'b0;
			high_freq_internal_osc_en_q <= 1'b0;
			mid_freq_internal_osc_en_q  <= 1'b0;
			low_freq_internal_osc_en_q  <= 1'b0;
			clk_source_q                <= `CSPM_SRC_PRIMARY;
			internal_path_q             <= `CSPM_PATH_HF;
			postscale_log2_q            <= `CSPM_DIV_MF1;
			cpu_clk_en_q                <= 1'b0;
			periph_clk_en_q             <= 1'b0;
			async_wake_en_q             <= 1'b0;
			device_reset_hold_q         <= 1'b1;
			mode_q                      <= `CSPM_MODE_PRI_RUN;
		end
		else
		begin
			// Crystal pins oscillate only in primary run or idle or while the reset hold is on, never in sleep
			primary_osc_en_q <= !prim_int && !sleep_q && (pri_sel || hold_reset);
			secondary_osc_en_q <= (sec_sel && !sleep_q) || timer_needs_sec;
			high_freq_internal_osc_en_q <= (int_block && !lf_direct &&
				path_d == `CSPM_PATH_HF) || (hold_reset && prim_int);
			mid_freq_internal_osc_en_q <= int_block && path_d == `CSPM_PATH_MF;
			low_freq_internal_osc_en_q <= lf_direct || watchdog_en || lf_keep ||
				(state_q == S_POWER_UP_TIMER);
			clk_source_q     <= src_d;
			internal_path_q  <= path_d;
			postscale_log2_q <= div_d;
			cpu_clk_en_q     <= booted && !sleep_q && !idle_q;
			periph_clk_en_q  <= booted && !sleep_q;
			async_wake_en_q  <= 1'b1;
			device_reset_hold_q <= hold_reset;
			if (sleep_q)
				mode_q <= `CSPM_MODE_SLEEP;
			else if (src_d == `CSPM_SRC_PRIMARY)
				mode_q <= idle_q ? `CSPM_MODE_PRIMARY_IDLE_MODE : `CSPM_MODE_PRI_RUN;
			else if (src_d == `CSPM_SRC_SECONDARY)
				mode_q <= idle_q ? `CSPM_MODE_SECONDARY_IDLE_MODE : `CSPM_MODE_SECONDARY_RUN_MODE;
			else
				mode_q <= idle_q ? `CSPM_MODE_INT_IDLE : `CSPM_MODE_INT_RUN;
		end
	end

	// ----------------------------------------
	// APB read path
	// ----------------------------------------
	wire start_stat = (clk_source_q == `CSPM_SRC_PRIMARY) && !prim_int && !hold_reset;
	wire hf_stable  = high_freq_internal_osc_en_q && hf_osc_ready;

	always @*
	begin
		rdata_d = 32'h00000000;
		err_d   = 1'b0;
		if (paddr == `CSPM_OFF_OSC_CTRL)
		begin
			rdata_d[`CSPM_BIT_IDLE]               = idle_on_sleep_select_q;
			rdata_d[`CSPM_FREQ_HI:`CSPM_FREQ_LO]  = internal_freq_select_q;
			rdata_d[`CSPM_BIT_START_STAT]         = start_stat;
			rdata_d[`CSPM_BIT_HF_STABLE]          = hf_stable;
			rdata_d[`CSPM_SRC_HI:`CSPM_SRC_LO]    = system_clock_source_select_q;
		end
		else if (paddr == `CSPM_OFF_OSC_SECOND)
			rdata_d[`CSPM_SECOND_W-1:0] = second_q;
		else if (paddr == `CSPM_OFF_STATUS)
			rdata_d[7:0] = {device_reset_hold_q, state_q, clk_source_q, mode_q[1:0]};
		else
			err_d = 1'b1;
	end

	// Answer one cycle after setup; the access phase always completes at once
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && err_d;
			if (psel && !penable && !pwrite)
				prdata <= rdata_d;
		end
	end

endmodule

`default_nettype wire

// >>> verification/cspm_top_asserts.sv
// Purpose: Port-level checks for clock source and power mode control
// Assumes: Parameters match those of the bound instance
// Notes:   Mode checks need the mode held two cycles, since enables lag their cause
`timescale 1ns/100ps
`default_nettype none

module cspm_top_asserts #(
	parameter PLL_LOCK_CYC = 80000
) (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Configuration
	input wire logic       pll_enable,
	input wire logic [3:0] primary_osc_config,
	// Watched outputs
	input wire logic       device_reset_hold_q,
	input wire logic [2:0] mode_q,
	input wire logic       cpu_clk_en_q,
	input wire logic       periph_clk_en_q,
	input wire logic       primary_osc_en_q,
	input wire logic       secondary_osc_en_q,
	input wire logic       high_freq_internal_osc_en_q,
	input wire logic       mid_freq_internal_osc_en_q,
	input wire logic [1:0] clk_source_q,
	input wire logic [1:0] internal_path_q,
	input wire logic       async_wake_en_q
);
	// ----------
	// Boot length counter
	// ----------
	// Only the first release is judged: a wake can rerun part of the chain
	logic [31:0] hold_cnt_q;
	logic        booted_q;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			hold_cnt_q <= 32'h0;
			booted_q   <= 1'b0;
		end
		else
		begin
			hold_cnt_q <= hold_cnt_q + {31'h0, device_reset_hold_q};
			booted_q   <= booted_q | ~device_reset_hold_q;
		end

	// ----------
	// Properties
	// ----------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	boot_lock_wait_a: assert property (
		$fell(device_reset_hold_q) && !booted_q && pll_enable && primary_osc_config <= 4'h3
		|-> hold_cnt_q >= 32'(PLL_LOCK_CYC + 1024))
		else $error("reset hold ended before start-up and lock waits");
	sleep_clocks_off_a: assert property (
		mode_q == 3'h6 && $past(mode_q) == 3'h6 |-> !cpu_clk_en_q && !periph_clk_en_q
		&& !primary_osc_en_q && !high_freq_internal_osc_en_q && !mid_freq_internal_osc_en_q)
		else $error("clock left running in sleep");
	primary_idle_mode_run_a: assert property (
		mode_q == 3'h3 && $past(mode_q) == 3'h3 |-> primary_osc_en_q)
		else $error("primary oscillator stopped in primary idle");
	pri_osc_off_a: assert property (
		mode_q inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6} && $stable(mode_q) |-> !primary_osc_en_q)
		else $error("primary oscillator running outside primary modes");
	sec_mode_clock_a: assert property (
		mode_q inside {3'h1, 3'h4} && $stable(mode_q)
		|-> secondary_osc_en_q && clk_source_q == 2'h1)
		else $error("secondary mode not clocked by secondary oscillator");
	int_mode_clock_a: assert property (
		mode_q inside {3'h2, 3'h5} && $stable(mode_q) |-> clk_source_q == 2'h2)
		else $error("internal mode not clocked by internal block");
	idle_cpu_off_a: assert property (
		mode_q inside {3'h3, 3'h4, 3'h5} && $stable(mode_q) |-> !cpu_clk_en_q && periph_clk_en_q)
		else $error("idle mode clocking wrong");
	lf_direct_off_a: assert property (
		clk_source_q == 2'h2 && internal_path_q == 2'h2 && $stable(internal_path_q)
		&& $stable(clk_source_q) |-> !high_freq_internal_osc_en_q && !mid_freq_internal_osc_en_q)
		else $error("high or mid oscillator on while low runs direct");
	async_wake_keep_a: assert property (
		async_wake_en_q |=> async_wake_en_q)
		else $error("clockless wake path dropped");
endmodule

bind cspm_top cspm_top_asserts #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) u_chk (
	.pclk, .presetn, .pll_enable, .primary_osc_config, .device_reset_hold_q, .mode_q,
	.cpu_clk_en_q, .periph_clk_en_q, .primary_osc_en_q, .secondary_osc_en_q,
	.high_freq_internal_osc_en_q, .mid_freq_internal_osc_en_q, .clk_source_q,
	.internal_path_q, .async_wake_en_q
);
`default_nettype wire

// >>> verification/cspm_top_bench.sv
// Purpose: Self-checking bench for the clock source and power mode block
// Assumes: Short lock and core-ready counts, oscillator ticks every second cycle
// Notes:   Inputs change on the rising edge, outputs are judged on the falling edge
`timescale 1ns/100ps
`default_nettype none

module cspm_top_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        power_up_timer_config, hf_start_wait_config, pll_enable, er;
	logic [3:0]  primary_osc_config, postscale_log2_q;
	logic        primary_osc_tick, low_freq_tick, hf_osc_ready, secondary_osc_running;
	logic        sleep_instr, wake_event, primary_osc_en_q, secondary_osc_en_q;
	logic        high_freq_internal_osc_en_q, mid_freq_internal_osc_en_q;
	logic        low_freq_internal_osc_en_q, cpu_clk_en_q, periph_clk_en_q;
	logic        async_wake_en_q, device_reset_hold_q;
	logic [1:0]  clk_source_q, internal_path_q;
	logic [2:0]  mode_q;
	int          n_errors, tests_run;

	cspm_top #(.PLL_LOCK_CYC(20), .CORE_READY_CYC(5)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.power_up_timer_config, .primary_osc_config, .hf_start_wait_config, .pll_enable,
		.primary_osc_tick, .low_freq_tick, .hf_osc_ready, .secondary_osc_running,
		.sleep_instr, .wake_event, .primary_osc_en_q, .secondary_osc_en_q,
		.high_freq_internal_osc_en_q, .mid_freq_internal_osc_en_q,
		.low_freq_internal_osc_en_q, .clk_source_q, .internal_path_q, .postscale_log2_q,
		.cpu_clk_en_q, .periph_clk_en_q, .async_wake_en_q, .device_reset_hold_q, .mode_q
	);

	// ----------
	// Helpers
	// ----------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench watchdog bounds this wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic look(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	task automatic pulse(input logic s);
		@(posedge pclk);
		sleep_instr <= s;
		wake_event  <= !s;
		@(posedge pclk);
		sleep_instr <= 1'b0;
		wake_event  <= 1'b0;
	endtask

	// Bounded, since a stuck hold would otherwise hang the run
	task automatic wait_boot(output int n);
		n = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (device_reset_hold_q !== 1'b0 && n < 20000);
	endtask

	// Returns internal path and divide exponent for a frequency code
	function automatic logic [5:0] fexp(input logic [2:0] c, input logic ls, input logic mp);
		if (c > 3'h2)
			return {2'h0, 4'h7 - {1'b0, c}};
		if (c == 3'h0 && !ls)
			return 6'h20;
		if (mp)
			return {2'h1, (c == 3'h2) ? 4'h0 : (c == 3'h1) ? 4'h1 : 4'h4};
		return {2'h0, (c == 3'h2) ? 4'h5 : (c == 3'h1) ? 4'h6 : 4'h9};
	endfunction

	// ----------
	// Scenarios
	// ----------
	task automatic t_boot;
		int n;
		wait_boot(n);
		chk("boot_len", 32'(n >= 6164 && n <= 6204), 1);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl_reset", rd & 32'hfb, 32'h38);
		apb(1'b0, 12'h004, 32'h0);
		chk("second_reset", rd, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		chk("status_booted", rd, 32'h40);
		apb(1'b1, 12'h00c, 32'hff);
		chk("unmapped_wr", er, 1);
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped_rd", {er, rd[30:0]}, 32'h80000000);
		$display("boot test done");
	endtask

	task automatic t_freq;
		logic [5:0]  e;
		logic [31:0] w;
		for (int c = 7; c >= 0; c--)
			for (int s = 0; s < 4; s++)
			begin
				w = {24'h0, 1'b0, 3'(c), 4'h2};
				apb(1'b1, 12'h004, 32'(s));
				apb(1'b1, 12'h000, w);
				apb(1'b0, 12'h000, 32'h0);
				chk("ctrl_rw", rd & 32'hfb, w);
				e = fexp(3'(c), s[0], s[1]);
				look(2);
				chk("clk_source", clk_source_q, 2);
				chk("path", internal_path_q, e[5:4]);
				if (e[5:4] != 2'h2)
					chk("postscale", postscale_log2_q, e[3:0]);
				else
					chk("hf_mf_off", {high_freq_internal_osc_en_q, mid_freq_internal_osc_en_q}, 0);
			end
		$display("frequency test done");
	endtask

	task automatic t_src;
		apb(1'b1, 12'h000, 32'h3d);
		look(3);
		chk("src_not_ready", clk_source_q, 2);
		@(posedge pclk);
		secondary_osc_running <= 1'b1;
		look(3);
		chk("src_sec", {clk_source_q, mode_q, secondary_osc_en_q}, 6'h13);
		apb(1'b0, 12'h000, 32'h0);
		chk("ro_status", rd[3], 0);
		apb(1'b1, 12'h000, 32'h73);
		look(3);
		chk("src_int", clk_source_q, 2);
		apb(1'b0, 12'h000, 32'h0);
		chk("hf_flag_low", rd[2], 0);
		@(posedge pclk);
		hf_osc_ready <= 1'b1;
		look(2);
		apb(1'b0, 12'h000, 32'h0);
		chk("hf_flag_high", rd[2], 1);
		apb(1'b1, 12'h000, 32'h30);
		look(3);
		chk("src_pri", {clk_source_q, primary_osc_en_q}, 3'h1);
		$display("source test done");
	endtask

	task automatic t_sleep;
		int         n;
		logic       idle;
		logic [1:0] src;
		logic [2:0] m;
		apb(1'b1, 12'h004, 32'h0c);
		for (int i = 0; i < 5; i++)
		begin
			idle = i < 3;
			src  = (i < 3) ? 2'(i) : (i == 3) ? 2'h2 : 2'h0;
			m    = idle ? 3'h3 + src : 3'h6;
			apb(1'b1, 12'h000, {24'h0, idle, 5'h18, src});
			look(3);
			pulse(1'b1);
			look(3);
			chk("sleep_mode", mode_q, m);
			chk("cpu_off", {cpu_clk_en_q, periph_clk_en_q}, idle);
			chk("pri_osc", primary_osc_en_q, idle && src == 2'h0);
			if (!idle)
				chk("sleep_keep", {low_freq_internal_osc_en_q, secondary_osc_en_q, async_wake_en_q}, 7);
			pulse(1'b0);
			look(3);
			chk("wake_hold", device_reset_hold_q, !idle && src == 2'h0);
			wait_boot(n);
			look(1);
			chk("wake_mode", mode_q, {1'b0, src});
		end
		$display("sleep test done");
	endtask

	task automatic t_hfwait;
		int n;
		@(posedge pclk);
		presetn               <= 1'b0;
		primary_osc_config    <= 4'h8;
		power_up_timer_config <= 1'b1;
		hf_osc_ready          <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		look(40);
		chk("hf_wait_hold", device_reset_hold_q, 1);
		@(posedge pclk);
		hf_osc_ready <= 1'b1;
		wait_boot(n);
		chk("hf_wait_end", 32'(n <= 8), 1);
		apb(1'b0, 12'h000, 32'h0);
		chk("start_status", rd[3], 0);
		$display("start wait test done");
	endtask

	// ----------
	// Run control
	// ----------
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		low_freq_tick    <= ~low_freq_tick;
		primary_osc_tick <= ~primary_osc_tick;
	end

	initial
	begin
		#(60000 * 25);
		n_errors++;
		test_done;
	end

	initial
	begin
		{n_errors, tests_run, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{power_up_timer_config, hf_start_wait_config, primary_osc_tick, low_freq_tick} = '0;
		{hf_osc_ready, secondary_osc_running, sleep_instr, wake_event} = '0;
		primary_osc_config = 4'h2;
		pll_enable = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_boot;
		t_freq;
		t_src;
		t_sleep;
		t_hfwait;
		test_done;
	end
endmodule
`default_nettype wire
